// [src/xlate_pkg.sv]
// Constants and carriers for the outbound window and utility block decoder
// ==========================================================================
// Notes on behaviour
// RQ1: Size code N gives window of 2^(N+1) bytes.
// RQ2: Size code zero disables outbound translation.
// RQ3: Valid codes 01011..11110; others reserved, software avoids.
// RQ4: One size sets processor and PCI windows.
// RQ5: Software aligns translation base to window size.
// RQ6: Base and size changes apply to later accesses.
// RQ7: Utility block relocatable by local and PCI bases.
// RQ8: Only 32-bit transfers to utility registers.
// RQ9: Keep local utility base outside outbound window.
// RQ10: Local offsets decode message, DMA, xlate, serial, interrupt.
// RQ11: Claim 4 Kbyte PCI region at PCI base.
// RQ12: PCI offsets decode message, DMA, xlate; rest reserved.
// RQ13: Utility block lives at or above 0x8000_0000.
// RQ14: Window base bits 30..12, bit 31 fixed one.
// RQ15: PCI address keeps offset, upper bits from base.
// RQ16: Translation register bits 11..5 read zero.
package xlate_pkg;

  // ========================================================================
  // Register offsets and fields
  localparam logic [19:0] OUT_BASE_OFS     = 20'h02300;
  localparam logic [19:0] OUT_XLATE_OFS    = 20'h02308;
  localparam int          SIZE_LSB         = 0;
  localparam int          SIZE_W           = 5;
  localparam int          BASE_LSB         = 12;
  localparam logic [4:0]  SIZE_RESET       = 5'h00;
  localparam logic [4:0]  SIZE_DISABLED    = 5'h00;
  localparam logic [4:0]  SIZE_MIN         = 5'h0B;
  localparam logic [4:0]  SIZE_MAX         = 5'h1E;
  localparam logic [19:0] XBASE_RESET      = 20'h00000;
  localparam logic [18:0] WBASE_RESET      = 19'h00000;

  // ========================================================================
  // Utility block decode
  localparam logic [31:0] UTIL_FLOOR       = 32'h80000000;
  localparam logic [31:0] UTIL_LOCAL_RESET = 32'h80000000;
  localparam logic [31:0] UTIL_PCI_RESET   = 32'h00000000;
  localparam int          LOCAL_SPAN_BITS  = 20;
  localparam int          PCI_SPAN_BITS    = 12;
  localparam logic [19:0] L_DMA_OFS        = 20'h01000;
  localparam logic [19:0] L_XLATE_OFS      = 20'h02000;
  localparam logic [19:0] L_SERIAL_OFS     = 20'h03000;
  localparam logic [19:0] L_RSVD_OFS       = 20'h04000;
  localparam logic [19:0] L_INTR_OFS       = 20'h40000;
  localparam logic [19:0] L_TOP_OFS        = 20'h80000;
  localparam logic [11:0] P_DMA_OFS        = 12'h100;
  localparam logic [11:0] P_XLATE_OFS      = 12'h300;
  localparam logic [11:0] P_RSVD_OFS       = 12'h400;

  typedef enum logic [2:0] {
    UNIT_NONE   = 3'b000,
    UNIT_MSG    = 3'b001,
    UNIT_DMA    = 3'b010,
    UNIT_XLATE  = 3'b011,
    UNIT_SERIAL = 3'b100,
    UNIT_INTR   = 3'b101,
    UNIT_RSVD   = 3'b110
  } unit_e;

  typedef struct packed {
    logic        hit;
    unit_e       unit;
    logic [19:0] offset;
  } decode_s;

  typedef struct packed {
    logic        hit;
    logic [31:0] addr;
  } xlate_s;

endpackage

// [src/outbound_window_and_util_decode.sv]
// Outbound window translation and utility register block address decode
module outbound_window_and_util_decode (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [19:0]         reg_offset,
  input  wire logic [31:0]         reg_wdata,
  output logic      [31:0]         reg_rdata,
  input  wire logic [31:0]         util_local_base,
  input  wire logic [31:0]         util_pci_base,
  input  wire logic                cpu_valid,
  input  wire logic [31:0]         cpu_addr,
  output xlate_pkg::xlate_s        out_xlate,
  output xlate_pkg::decode_s       local_dec,
  input  wire logic                pci_valid,
  input  wire logic [31:0]         pci_addr,
  output xlate_pkg::decode_s       pci_dec
);

  // ========================================================================
  // Registers
  logic [18:0] wbase_reg;
  logic [19:0] xbase_reg;
  logic [4:0]  size_reg;
  logic [31:0] rdata_next;

  // ========================================================================
  // Strobes and fields
  // Strobes already carry the offset match, so writes elsewhere fall through
  wire        wr_wbase     = reg_wr && (reg_offset == xlate_pkg::OUT_BASE_OFS);
  wire        wr_xlate     = reg_wr && (reg_offset == xlate_pkg::OUT_XLATE_OFS);
  wire        sel_wbase    = (reg_offset == xlate_pkg::OUT_BASE_OFS);
  wire        sel_xlate    = (reg_offset == xlate_pkg::OUT_XLATE_OFS);
  wire [18:0] wbase_field  = reg_wdata[30:12];                                  // [RQ14]
  wire [19:0] xbase_field  = reg_wdata[31:12];
  wire [4:0]  size_field   = reg_wdata[4:0];                                    // [RQ16]
  // Bit 31 of the window base reads one; reserved fields read zero
  wire [31:0] wbase_rdback = {1'b1, wbase_reg, 12'h000};                        // [RQ14]
  wire [31:0] xlate_rdback = {xbase_reg, 7'h00, size_reg};                      // [RQ16]

  // ========================================================================
  // Register state
  // New values take effect on the next access; no drain is needed since
  // translation is purely combinational on the live registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wbase_reg <= xlate_pkg::WBASE_RESET;
    end else if (ce && wr_wbase) begin
      wbase_reg <= wbase_field; // [RQ14] [RQ6]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      xbase_reg <= xlate_pkg::XBASE_RESET;
      size_reg  <= xlate_pkg::SIZE_RESET;
    end else if (ce && wr_xlate) begin
      xbase_reg <= xbase_field; // [RQ6]
      size_reg  <= size_field;  // [RQ6] [RQ16]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (ce && reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  assign rdata_next = sel_wbase ? wbase_rdback :
                      sel_xlate ? xlate_rdback :
                                  32'h00000000;

  // ========================================================================
  // Outbound translation
  // Mask covers offset bits below 2^(N+1); reserved codes are not trapped
  wire [5:0]  span_bits   = {1'b0, size_reg} + 6'h01;                            // [RQ1] [RQ3]
  logic [31:0] offset_mask;
  // Bit i belongs to the offset while i lies below N+1
  for (genvar i = 0; i < 32; i++) begin : g_mask
    assign offset_mask[i] = (6'(i) < span_bits);                                 // [RQ1]
  end
  wire [31:0] wbase_full  = {1'b1, wbase_reg, 12'h000};                         // [RQ14]
  wire [31:0] xbase_full  = {xbase_reg, 12'h000};
  wire        xlate_on    = (size_reg != xlate_pkg::SIZE_DISABLED);             // [RQ2]
  // Same mask frames both the processor window and PCI window
  wire        win_hit     = xlate_on && cpu_valid &&
                            ((cpu_addr & ~offset_mask) == (wbase_full & ~offset_mask)); // [RQ4]

  assign out_xlate.hit  = win_hit;
  assign out_xlate.addr = win_hit ? ((xbase_full & ~offset_mask) | (cpu_addr & offset_mask))
                                  : 32'h00000000;                               // [RQ15]

  // ========================================================================
  // Local utility block decode: 1 Mbyte span
  wire [31:0] loc_delta = cpu_addr - util_local_base;                           // [RQ7]
  wire        loc_in    = cpu_valid && (util_local_base >= xlate_pkg::UTIL_FLOOR) &&
                          (cpu_addr >= util_local_base) &&
                          (loc_delta[31:xlate_pkg::LOCAL_SPAN_BITS] == 12'h000); // [RQ13]
  wire [19:0] loc_ofs   = loc_delta[19:0];
  xlate_pkg::unit_e loc_unit;

  assign loc_unit = (loc_ofs <  xlate_pkg::L_DMA_OFS)    ? xlate_pkg::UNIT_MSG :
                    (loc_ofs <  xlate_pkg::L_XLATE_OFS)  ? xlate_pkg::UNIT_DMA :
                    (loc_ofs <  xlate_pkg::L_SERIAL_OFS) ? xlate_pkg::UNIT_XLATE :
                    (loc_ofs <  xlate_pkg::L_RSVD_OFS)   ? xlate_pkg::UNIT_SERIAL :
                    (loc_ofs <  xlate_pkg::L_INTR_OFS)   ? xlate_pkg::UNIT_RSVD :
                    (loc_ofs <  xlate_pkg::L_TOP_OFS)    ? xlate_pkg::UNIT_INTR :
                                                           xlate_pkg::UNIT_RSVD; // [RQ10]

  assign local_dec.hit    = loc_in;
  assign local_dec.unit   = loc_in ? loc_unit : xlate_pkg::UNIT_NONE;
  assign local_dec.offset = loc_in ? loc_ofs : 20'h00000;

  // ========================================================================
  // PCI utility region decode: 4 Kbyte span
  wire [31:0] pci_delta = pci_addr - util_pci_base;                             // [RQ7]
  wire        pci_in    = pci_valid && (pci_addr >= util_pci_base) &&
                          (pci_delta[31:xlate_pkg::PCI_SPAN_BITS] == 20'h00000); // [RQ11]
  wire [11:0] pci_ofs   = pci_delta[11:0];
  xlate_pkg::unit_e pci_unit;

  assign pci_unit = (pci_ofs < xlate_pkg::P_DMA_OFS)   ? xlate_pkg::UNIT_MSG :
                    (pci_ofs < xlate_pkg::P_XLATE_OFS) ? xlate_pkg::UNIT_DMA :
                    (pci_ofs < xlate_pkg::P_RSVD_OFS)  ? xlate_pkg::UNIT_XLATE :
                                                         xlate_pkg::UNIT_RSVD;  // [RQ12]

  assign pci_dec.hit    = pci_in;
  assign pci_dec.unit   = pci_in ? pci_unit : xlate_pkg::UNIT_NONE;
  assign pci_dec.offset = pci_in ? {8'h00, pci_ofs} : 20'h00000;

endmodule

// [dv/owd_assertions.sv]
// Port checks for the outbound window and utility block decoder
module owd_assertions (
  input wire logic               clk, resetn, ce, reg_wr, reg_rd, cpu_valid, pci_valid,
  input wire logic [19:0]        reg_offset,
  input wire logic [31:0]        reg_wdata, reg_rdata, util_local_base, util_pci_base, cpu_addr, pci_addr,
  input wire xlate_pkg::xlate_s  out_xlate,
  input wire xlate_pkg::decode_s local_dec, pci_dec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] size_reg;
  wire        xw = ce && reg_wr && reg_offset == xlate_pkg::OUT_XLATE_OFS;
  wire        xr = ce && reg_rd && reg_offset == xlate_pkg::OUT_XLATE_OFS;
  wire        br = ce && reg_rd && reg_offset == xlate_pkg::OUT_BASE_OFS;
  // Shadow of the size field, so checks need not see inside
  always_ff @(posedge clk) begin
    if (!resetn) size_reg <= 5'h00;
    else if (xw) size_reg <= reg_wdata[4:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_size_off_nohit: assert property (size_reg == 5'h00 |-> !out_xlate.hit) else $error("hit with size zero");
  chk_xlate_low_kept: assert property (out_xlate.hit |-> out_xlate.addr[11:0] == cpu_addr[11:0])
    else $error("offset bits not kept");
  chk_win_upper_half: assert property (out_xlate.hit |-> cpu_valid && cpu_addr[31]) else $error("hit in low half");
  chk_xlate_rd_rsvd: assert property (xr |=> reg_rdata[11:0] == {7'h00, $past(size_reg)})
    else $error("translation readback wrong");
  chk_base_rd_msb: assert property (br |=> reg_rdata[31] && reg_rdata[11:0] == 12'h000) else $error("base readback");
  chk_pci_claim_4k: assert property (pci_dec.hit == (pci_valid && pci_addr[31:12] == util_pci_base[31:12]))
    else $error("pci claim wrong");
  chk_pci_xlate_unit: assert property (pci_dec.hit && pci_addr[11:8] == 4'h3 |-> pci_dec.unit == xlate_pkg::UNIT_XLATE)
    else $error("pci xlate unit");
  chk_pci_rsvd_unit: assert property (pci_dec.hit && pci_addr[11:10] != 2'b00 |-> pci_dec.unit == xlate_pkg::UNIT_RSVD)
    else $error("pci reserved unit");
  chk_local_floor: assert property (local_dec.hit |-> util_local_base[31]) else $error("block below floor");
  chk_local_intr: assert property (local_dec.hit && cpu_addr[19:18] == 2'b01 |-> local_dec.unit == xlate_pkg::UNIT_INTR)
    else $error("local intr unit");
endmodule

// [dv/host_model.sv]
// Processor and PCI master stand-in: access addresses and block bases
module host_model (
  input  wire logic   clk,
  output logic        cpu_valid,
  output logic        pci_valid,
  output logic [31:0] cpu_addr,
  output logic [31:0] pci_addr,
  output logic [31:0] util_local_base,
  output logic [31:0] util_pci_base
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        cv   = 1'b0;
  logic        pv   = 1'b0;
  logic [31:0] ca   = 32'h00000000;
  logic [31:0] pa   = 32'h00000000;
  logic [31:0] lb   = xlate_pkg::UTIL_LOCAL_RESET;
  logic [31:0] pb   = 32'h00000000;
  logic [31:0] idle = 32'h00000000;
  // Idle address lines toggle so a decoder that ignores valid shows it
  always @(negedge clk) begin
    idle            <= ~idle;
    cpu_valid       <= cv;
    pci_valid       <= pv;
    cpu_addr        <= cv ? ca : idle;
    pci_addr        <= pv ? pa : idle;
    util_local_base <= lb;
    util_pci_base   <= pb;
  end
  // Whole 32-bit addresses only, settled before return
  task automatic acc(logic v, logic [31:0] a, logic w, logic [31:0] b);
    @(posedge clk);
    {cv, ca, pv, pa} = {v, a, w, b};
    @(negedge clk);
    #1;
  endtask
  task automatic bases(logic [31:0] l, logic [31:0] p);
    @(posedge clk);
    {lb, pb} = {l, p};
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the outbound window and utility decoder
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, ce, reg_wr, reg_rd, cv, pv;
  logic [19:0] reg_offset;
  logic [31:0] reg_wdata, reg_rdata, lb, pb, ca, pa;
  xlate_pkg::xlate_s  out_xlate;
  xlate_pkg::decode_s local_dec, pci_dec;
  int failures = 0, cmp_count = 0, cyc = 0;
  int lo[8] = '{'h0, 'h1000, 'h2000, 'h3000, 'h4000, 'h3FFFC, 'h40000, 'h80000};
  int lu[8] = '{1, 2, 3, 4, 6, 6, 5, 6};
  int po[8] = '{'h0, 'hFF, 'h100, 'h2FF, 'h300, 'h3FF, 'h400, 'hFFF};
  int pu[8] = '{1, 1, 2, 2, 3, 3, 6, 6};
  outbound_window_and_util_decode outbound_window_and_util_decode_i (.clk(clk), .resetn(resetn), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_offset(reg_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .util_local_base(lb), .util_pci_base(pb), .cpu_valid(cv), .cpu_addr(ca), .out_xlate(out_xlate),
    .local_dec(local_dec), .pci_valid(pv), .pci_addr(pa), .pci_dec(pci_dec));
  host_model host_model_i (.clk(clk), .cpu_valid(cv), .pci_valid(pv), .cpu_addr(ca), .pci_addr(pa),
    .util_local_base(lb), .util_pci_base(pb));
  // ==========================================================================
  // Shared tasks
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [19:0] o, logic [31:0] d);
    @(negedge clk);
    {reg_wr, reg_offset, reg_wdata} = {1'b1, o, d};
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [19:0] o, logic [31:0] e);
    @(negedge clk);
    {reg_rd, reg_offset} = {1'b1, o};
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rdata", reg_rdata, e);
  endtask
  task automatic xl(logic [31:0] a, logic h, logic [31:0] e);
    host_model_i.acc(1'b1, a, 1'b0, 32'h0);
    chk("xlate_hit", 32'(out_xlate.hit), 32'(h));
    chk("xlate_addr", out_xlate.addr, e);
  endtask
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(xlate_pkg::OUT_XLATE_OFS, 32'h00000000);
    rd(xlate_pkg::OUT_BASE_OFS, 32'h80000000);
    wr(20'h02304, 32'hFFFFFFFF);
    rd(20'h02304, 32'h00000000);
  endtask
  // Low enable freezes registers and read data alike
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    wr(xlate_pkg::OUT_XLATE_OFS, 32'hFFFFF01E);
    rd(xlate_pkg::OUT_BASE_OFS, 32'h00000000);
    ce = 1'b1;
    rd(xlate_pkg::OUT_XLATE_OFS, 32'h00000000);
  endtask
  // Window and translation base kept aligned to the size in use
  task automatic t_window();
    wr(xlate_pkg::OUT_BASE_OFS, 32'h10010000);
    rd(xlate_pkg::OUT_BASE_OFS, 32'h90010000);
    wr(xlate_pkg::OUT_XLATE_OFS, 32'h12345FEB);
    rd(xlate_pkg::OUT_XLATE_OFS, 32'h1234500B);
    xl(32'h90010ABC, 1'b1, 32'h12345ABC);
    xl(32'h90011000, 1'b0, 32'h0);
    xl(32'h10010ABC, 1'b0, 32'h0);
    wr(xlate_pkg::OUT_XLATE_OFS, 32'h2000000C);
    xl(32'h90011004, 1'b1, 32'h20001004);
    wr(xlate_pkg::OUT_BASE_OFS, 32'h80000000);
    wr(xlate_pkg::OUT_XLATE_OFS, 32'h0000001E);
    xl(32'hFFFFFFF0, 1'b1, 32'h7FFFFFF0);
    wr(xlate_pkg::OUT_XLATE_OFS, 32'h12345000);
    xl(32'h80000010, 1'b0, 32'h0);
  endtask
  // Local block unit and offset decode, then no hit with a base below the floor
  task automatic t_local();
    host_model_i.bases(32'h80100000, 32'h40001000);
    for (int i = 0; i < 8; i++) begin
      host_model_i.acc(1'b1, 32'h80100000 | lo[i], 1'b0, 32'h0);
      chk("local_hit", 32'(local_dec.hit), 32'h1);
      chk("local_unit", 32'(local_dec.unit), lu[i]);
      chk("local_ofs", 32'(local_dec.offset), lo[i]);
    end
    host_model_i.bases(32'h7FF00000, 32'h40001000);
    host_model_i.acc(1'b1, 32'h7FF01000, 1'b0, 32'h0);
    chk("local_hit", 32'(local_dec.hit), 32'h0);
  endtask
  task automatic t_pci();
    for (int i = 0; i < 8; i++) begin
      host_model_i.acc(1'b0, 32'h0, 1'b1, 32'h40001000 | po[i]);
      chk("pci_hit", 32'(pci_dec.hit), 32'h1);
      chk("pci_unit", 32'(pci_dec.unit), pu[i]);
      chk("pci_ofs", 32'(pci_dec.offset), po[i]);
    end
    host_model_i.acc(1'b0, 32'h0, 1'b1, 32'h40002000);
    chk("pci_hit", 32'(pci_dec.hit), 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {ce, reg_wr, reg_rd, resetn, reg_offset, reg_wdata} = {4'b1000, 52'h0};
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_regs();
    t_freeze();
    t_window();
    t_local();
    t_pci();
    test_done();
  end
endmodule
bind outbound_window_and_util_decode owd_assertions owd_assertions_i (.clk(clk), .resetn(resetn), .ce(ce),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .cpu_valid(cpu_valid), .pci_valid(pci_valid), .reg_offset(reg_offset),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .util_local_base(util_local_base), .util_pci_base(util_pci_base),
  .cpu_addr(cpu_addr), .pci_addr(pci_addr), .out_xlate(out_xlate), .local_dec(local_dec), .pci_dec(pci_dec));
